// *** common/dfc_defs.svh ***
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH
// How it works
// - function 1 sets, 2 reads state, 3 reads flags
// - option bit0 makes set persistent across power
// - success gives error 00h, status 50h
// - return-state: low byte count, high byte number
// - return-flags likewise; other functions reserved outputs
// - feature 1: cache policy, default defer
// - forced cache: set-features accepted, no effect
// - feature 2: reordering, state 2 accepted, ignored
// - feature 3: logging interval, zero invalid
// - interval set resets history queue: entry 0 current temp, rest 80h
// - queue reset keeps period and limits

// ***********************
// register offsets (bytes)
// ***********************
`define DFC_OFF_FUNC 8'h00
`define DFC_OFF_FEAT 8'h04
`define DFC_OFF_STATE 8'h08
`define DFC_OFF_OPT 8'h0c
`define DFC_OFF_GO 8'h10
`define DFC_OFF_RESULT 8'h14
`define DFC_OFF_STAT 8'h18
`define DFC_OFF_HIST 8'h1c
`define DFC_OFF_LIMITS 8'h20
// status, go and option register field positions
`define DFC_STAT_WC_BIT 5
`define DFC_STAT_BUSY_BIT 8
`define DFC_STAT_HBUSY_BIT 9
`define DFC_GO_BIT 0
`define DFC_OPT_PERSIST_BIT 0
// ***********************
// codes and defaults
// ***********************
`define DFC_FN_SET 16'h0001
`define DFC_FN_GET 16'h0002
`define DFC_FN_FLAGS 16'h0003
`define DFC_FT_WCACHE 16'h0001
`define DFC_FT_REORDER 16'h0002
`define DFC_FT_INTERVAL 16'h0003
`define DFC_WC_DEFER 16'h0001
`define DFC_WC_FORCE_ON 16'h0002
`define DFC_WC_FORCE_OFF 16'h0003
`define DFC_RO_ENABLE 16'h0001
`define DFC_RO_DISABLE 16'h0002
`define DFC_INT_INVALID 16'h0000
`define DFC_INT_DEFAULT 16'h0001
`define DFC_ERR_OK 8'h00
`define DFC_STS_OK 8'h50
`define DFC_ERR_ABORT 8'h04
`define DFC_STS_ERR 8'h51
`define DFC_HIST_EMPTY 8'h80
`define DFC_HIST_DEPTH 128
// ***********************
// timing
// ***********************
`define DFC_MIN_SECONDS 60
`define DFC_CLK_MHZ 100
`endif

// *** common/dfc_pkg.sv ***
package dfc_pkg;
  typedef enum logic [1:0] {
    DFC_CMD_IDLE = 2'b01,
    DFC_CMD_EXEC = 2'b10
  } dfc_cmd_t;
  typedef enum logic [1:0] {
    DFC_HQ_RUN = 2'b01,
    DFC_HQ_CLEAR = 2'b10
  } dfc_hq_t;
endpackage

// *** hw/dfc_hist.sv ***
`timescale 1ns/100ps
`include "dfc_defs.svh"
module dfc_hist #(
  parameter int DEPTH = `DFC_HIST_DEPTH,
  parameter longint CYC_PER_MIN = 64'(`DFC_MIN_SECONDS) * 64'(`DFC_CLK_MHZ) * 64'd1000000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear_in,
  input wire logic [7:0] temp_in,
  input wire logic [15:0] interval_in,
  input wire logic [6:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic [6:0] idx_out,
  output logic busy_out
);
  // index and pointers are 7 bits wide, so only a 128-entry queue fits
  if (DEPTH != 128 || CYC_PER_MIN < 1) begin
    $error("dfc_hist: unsupported parameters");
  end
  logic [7:0] mem [0:DEPTH-1];
  dfc_pkg::dfc_hq_t st;
  logic [6:0] clr_ptr;
  logic [35:0] cyc_cnt;
  logic [15:0] min_cnt;
  logic tick;

  assign tick = (cyc_cnt == 36'(CYC_PER_MIN - 1));
  assign busy_out = (st == dfc_pkg::DFC_HQ_CLEAR);
  assign rd_data_out = mem[rd_idx_in];

  // ***********************
  // minute timer; restarts with each queue reset
  // ***********************
  always_ff @(posedge clk) begin
    if (srst || clear_in || tick) begin
      cyc_cnt <= 36'h0;
    end else begin
      cyc_cnt <= cyc_cnt + 36'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || clear_in) begin
      min_cnt <= 16'h0;
    end else if (tick) begin
      min_cnt <= (min_cnt + 16'h1 >= interval_in) ? 16'h0 : min_cnt + 16'h1;
    end
  end

  // ***********************
  // queue: index zero, first entry current temp, rest 80h
  // ***********************
  always_ff @(posedge clk) begin
    if (srst || clear_in) begin
      st <= dfc_pkg::DFC_HQ_CLEAR;
      clr_ptr <= 7'h1;
      idx_out <= 7'h0;
    end else begin
      case (st)
        dfc_pkg::DFC_HQ_CLEAR: begin
          clr_ptr <= clr_ptr + 7'h1;
          if (clr_ptr == 7'h7f) begin
            st <= dfc_pkg::DFC_HQ_RUN;
          end
        end
        default: begin
          if (tick && min_cnt + 16'h1 >= interval_in) begin
            idx_out <= idx_out + 7'h1;
          end
        end
      endcase
    end
  end

  // period and limits live elsewhere and are never touched here
  always_ff @(posedge clk) begin
    if (srst || clear_in) begin
      mem[0] <= temp_in;
    end else if (st == dfc_pkg::DFC_HQ_CLEAR) begin
      mem[clr_ptr] <= `DFC_HIST_EMPTY;
    end else if (tick && min_cnt + 16'h1 >= interval_in) begin
      mem[idx_out + 7'h1] <= temp_in;
    end
  end
endmodule

// *** hw/dfc_top.sv ***
`timescale 1ns/100ps
`include "dfc_defs.svh"
module dfc_top #(
  parameter longint CYC_PER_MIN = 64'(`DFC_MIN_SECONDS) * 64'(`DFC_CLK_MHZ) * 64'd1000000,
  parameter logic [15:0] SAMPLE_PERIOD = 16'h0001,
  parameter logic [7:0] MAX_OP_LIMIT = 8'h3c,
  parameter logic [7:0] OVER_LIMIT = 8'h46,
  parameter logic [7:0] MIN_OP_LIMIT = 8'h05,
  parameter logic [7:0] UNDER_LIMIT = 8'h00
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // drive core
  input wire logic HARD_RST_IN,
  input wire logic SETF_WC_VALID_IN,
  input wire logic SETF_WC_EN_IN,
  input wire logic [7:0] CUR_TEMP_IN,
  output logic SETF_ACK_OUT,
  output logic WC_ACTIVE_OUT,
  output logic IDENT_W85_B5_OUT,
  output logic REORDER_EN_OUT
);
  if (CYC_PER_MIN < 1) begin
    $error("dfc_top: CYC_PER_MIN must be positive");
  end

  dfc_pkg::dfc_cmd_t st;
  logic [15:0] func, feat, state, opt;
  logic [7:0] res_err, res_sts, res_cnt, res_num;
  logic [15:0] wc_pol, wc_pol_nv, int_val, int_val_nv;
  logic [2:0] persist;
  logic wc_setf, wc_true;
  logic [6:0] hist_rd;
  logic [7:0] hist_data;
  logic [6:0] hist_idx;
  logic hist_busy, hist_clear;
  logic apb_acc, apb_wr, apb_rd;
  logic next_abort, next_apply;
  logic [15:0] next_out;

  assign apb_acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign apb_wr = apb_acc && PWRITE_IN;
  assign apb_rd = PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN;

  // ***********************
  // apb handshake: one wait state per access
  // ***********************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT && (PADDR_IN > `DFC_OFF_LIMITS
        || PADDR_IN[1:0] != 2'b00);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      PRDATA_OUT <= 32'h0;
    end else if (apb_rd) begin
      if (PADDR_IN == `DFC_OFF_FUNC) begin
        PRDATA_OUT <= {16'h0, func};
      end else if (PADDR_IN == `DFC_OFF_FEAT) begin
        PRDATA_OUT <= {16'h0, feat};
      end else if (PADDR_IN == `DFC_OFF_STATE) begin
        PRDATA_OUT <= {16'h0, state};
      end else if (PADDR_IN == `DFC_OFF_OPT) begin
        PRDATA_OUT <= {16'h0, opt};
      end else if (PADDR_IN == `DFC_OFF_RESULT) begin
        PRDATA_OUT <= {res_num, res_cnt, res_sts, res_err};
      end else if (PADDR_IN == `DFC_OFF_STAT) begin
        // upper half shows the sampling period, which queue resets never touch
        PRDATA_OUT <= {SAMPLE_PERIOD, 6'h0, hist_busy, st == dfc_pkg::DFC_CMD_EXEC, 2'b00,
          wc_true, 5'h0};
      end else if (PADDR_IN == `DFC_OFF_HIST) begin
        PRDATA_OUT <= {8'h0, hist_data, 1'b0, hist_idx, 1'b0, hist_rd};
      end else if (PADDR_IN == `DFC_OFF_LIMITS) begin
        PRDATA_OUT <= {UNDER_LIMIT, MIN_OP_LIMIT, OVER_LIMIT, MAX_OP_LIMIT};
      end else begin
        PRDATA_OUT <= 32'h0;
      end
    end
  end

  // ***********************
  // command key registers
  // ***********************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      func <= 16'h0;
      feat <= 16'h0;
      state <= 16'h0;
      opt <= 16'h0;
      hist_rd <= 7'h0;
    end else if (apb_wr && st == dfc_pkg::DFC_CMD_IDLE) begin
      if (PADDR_IN == `DFC_OFF_FUNC) begin
        func <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `DFC_OFF_FEAT) begin
        feat <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `DFC_OFF_STATE) begin
        state <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `DFC_OFF_OPT) begin
        opt <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `DFC_OFF_HIST) begin
        hist_rd <= PWDATA_IN[6:0];
      end
    end
  end

  // writes to GO while a command runs are dropped
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      st <= dfc_pkg::DFC_CMD_IDLE;
    end else begin
      case (st)
        dfc_pkg::DFC_CMD_IDLE: begin
          if (apb_wr && PADDR_IN == `DFC_OFF_GO && PWDATA_IN[`DFC_GO_BIT]) begin
            st <= dfc_pkg::DFC_CMD_EXEC;
          end
        end
        default: begin
          st <= dfc_pkg::DFC_CMD_IDLE;
        end
      endcase
    end
  end

  // ***********************
  // decode of the latched command
  // ***********************
  always_comb begin
    next_abort = 1'b0;
    next_apply = 1'b0;
    next_out = 16'h0;
    case (func)
      `DFC_FN_SET: begin
        if (feat == `DFC_FT_WCACHE) begin
          next_abort = state < `DFC_WC_DEFER || state > `DFC_WC_FORCE_OFF;
        end else if (feat == `DFC_FT_REORDER) begin
          next_abort = state != `DFC_RO_ENABLE && state != `DFC_RO_DISABLE;
        end else if (feat == `DFC_FT_INTERVAL) begin
          next_abort = state == `DFC_INT_INVALID;
        end else begin
          next_abort = 1'b1;
        end
        next_apply = !next_abort;
      end
      `DFC_FN_GET: begin
        if (feat == `DFC_FT_WCACHE) begin
          next_out = wc_pol;
        end else if (feat == `DFC_FT_REORDER) begin
          next_out = `DFC_RO_ENABLE;
        end else if (feat == `DFC_FT_INTERVAL) begin
          next_out = int_val;
        end else begin
          next_abort = 1'b1;
        end
      end
      `DFC_FN_FLAGS: begin
        if (feat >= `DFC_FT_WCACHE && feat <= `DFC_FT_INTERVAL) begin
          next_out = {15'h0, persist[feat[1:0] - 2'd1]};
        end else begin
          next_abort = 1'b1;
        end
      end
      default: begin
        next_abort = 1'b1;
      end
    endcase
  end

  // reserved outputs read as zero
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      res_err <= `DFC_ERR_OK;
      res_sts <= `DFC_STS_OK;
      res_cnt <= 8'h0;
      res_num <= 8'h0;
    end else if (st == dfc_pkg::DFC_CMD_EXEC) begin
      res_err <= next_abort ? `DFC_ERR_ABORT : `DFC_ERR_OK;
      res_sts <= next_abort ? `DFC_STS_ERR : `DFC_STS_OK;
      res_cnt <= next_out[7:0];
      res_num <= next_out[15:8];
    end
  end

  // ***********************
  // feature state, volatile and persistent copies
  // ***********************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wc_pol <= `DFC_WC_DEFER;
      wc_pol_nv <= `DFC_WC_DEFER;
      int_val <= `DFC_INT_DEFAULT;
      int_val_nv <= `DFC_INT_DEFAULT;
      persist <= 3'h0;
    end else if (HARD_RST_IN) begin
      wc_pol <= wc_pol_nv;
      int_val <= int_val_nv;
    end else if (st == dfc_pkg::DFC_CMD_EXEC && next_apply) begin
      if (feat == `DFC_FT_WCACHE) begin
        wc_pol <= state;
        persist[0] <= opt[`DFC_OPT_PERSIST_BIT];
        if (opt[`DFC_OPT_PERSIST_BIT]) begin
          wc_pol_nv <= state;
        end
      end else if (feat == `DFC_FT_REORDER) begin
        persist[1] <= opt[`DFC_OPT_PERSIST_BIT];
      end else begin
        int_val <= state;
        persist[2] <= opt[`DFC_OPT_PERSIST_BIT];
        if (opt[`DFC_OPT_PERSIST_BIT]) begin
          int_val_nv <= state;
        end
      end
    end
  end

  assign hist_clear = st == dfc_pkg::DFC_CMD_EXEC && next_apply
    && feat == `DFC_FT_INTERVAL;

  // ***********************
  // write cache operating state
  // ***********************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wc_setf <= 1'b1;
      SETF_ACK_OUT <= 1'b0;
    end else begin
      SETF_ACK_OUT <= SETF_WC_VALID_IN;
      if (SETF_WC_VALID_IN && wc_pol == `DFC_WC_DEFER) begin
        wc_setf <= SETF_WC_EN_IN;
      end
    end
  end

  assign wc_true = (wc_pol == `DFC_WC_DEFER) ? wc_setf : (wc_pol == `DFC_WC_FORCE_ON);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      WC_ACTIVE_OUT <= 1'b0;
      IDENT_W85_B5_OUT <= 1'b0;
      REORDER_EN_OUT <= 1'b0;
    end else begin
      WC_ACTIVE_OUT <= wc_true;
      IDENT_W85_B5_OUT <= wc_true;
      REORDER_EN_OUT <= 1'b1;
    end
  end

  // sampling period is a fixed parameter, untouched by queue resets
  dfc_hist #(
    .DEPTH(`DFC_HIST_DEPTH),
    .CYC_PER_MIN(CYC_PER_MIN)
  ) u_hist (
    .clk(CLK_IN),
    .srst(SRST_IN),
    .clear_in(hist_clear),
    .temp_in(CUR_TEMP_IN),
    .interval_in(int_val),
    .rd_idx_in(hist_rd),
    .rd_data_out(hist_data),
    .idx_out(hist_idx),
    .busy_out(hist_busy)
  );
endmodule

// *** sim/dfc_props.sv ***
`timescale 1ns/100ps
// ****
// port checker
// ****
module dfc_props (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic HARD_RST_IN,
  input wire logic SETF_WC_VALID_IN,
  input wire logic SETF_ACK_OUT,
  input wire logic WC_ACTIVE_OUT,
  input wire logic IDENT_W85_B5_OUT,
  input wire logic REORDER_EN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // cycles since anything that may move the cache state
  logic [2:0] quiet;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || HARD_RST_IN || SETF_WC_VALID_IN || (PREADY_OUT && PWRITE_IN)) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  a_ack_follows: assert property (SETF_WC_VALID_IN |=> SETF_ACK_OUT)
    else $error("set-features not acknowledged");
  a_ack_only_req: assert property (!SETF_WC_VALID_IN |=> !SETF_ACK_OUT)
    else $error("spurious acknowledge");
  a_ident_tracks: assert property (IDENT_W85_B5_OUT == WC_ACTIVE_OUT)
    else $error("identify bit differs from cache state");
  a_reorder_kept: assert property (!$past(SRST_IN) |-> REORDER_EN_OUT)
    else $error("reordering dropped");
  a_wc_has_cause: assert property ($changed(WC_ACTIVE_OUT) |-> quiet < 3'h4)
    else $error("cache state moved without cause");
  a_ready_wait: assert property ($rose(PENABLE_IN) && PSEL_IN |-> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not after one wait state");
  a_ready_once: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  a_err_map: assert property (PREADY_OUT |-> PSLVERR_OUT == (PADDR_IN > 8'h20
    || PADDR_IN[1:0] != 2'h0)) else $error("slave error mismatch");
  c_err: cover property (PREADY_OUT && PSLVERR_OUT);
  c_ack: cover property (SETF_WC_VALID_IN ##1 SETF_ACK_OUT);
  c_wc_off: cover property ($fell(WC_ACTIVE_OUT));
endmodule
bind dfc_top dfc_props u_props (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .HARD_RST_IN(HARD_RST_IN),
  .SETF_WC_VALID_IN(SETF_WC_VALID_IN), .SETF_ACK_OUT(SETF_ACK_OUT),
  .WC_ACTIVE_OUT(WC_ACTIVE_OUT), .IDENT_W85_B5_OUT(IDENT_W85_B5_OUT),
  .REORDER_EN_OUT(REORDER_EN_OUT));

// *** sim/dfc_host.sv ***
`timescale 1ns/100ps
// ****
// host side: set-features requests and temperature
// ****
module dfc_host (
  input wire logic clk_in,
  output logic valid_out,
  output logic en_out,
  output logic [7:0] temp_out
);
  initial begin
    valid_out = 1'b0;
    en_out = 1'b0;
    temp_out = 8'h19;
  end
  // one-cycle request; the released value line is inverted, never left stale
  task automatic setf(input logic en);
    @(posedge clk_in);
    valid_out <= 1'b1;
    en_out <= en;
    @(posedge clk_in);
    valid_out <= 1'b0;
    en_out <= ~en;
  endtask
  task automatic set_temp(input logic [7:0] v);
    temp_out <= v;
  endtask
endmodule

// *** sim/dfc_top_tb.sv ***
`timescale 1ns/100ps
`include "dfc_defs.svh"
module dfc_top_tb;
  // ****
  // stimulus and checking
  // ****
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic hrst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic prdy, perr, sv, se, wca;
  localparam logic [15:0] sample_period = 16'h0007;
  logic [7:0] temp;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h2d;
  logic [31:0] r;
  logic [15:0] st;
  logic [7:0] t;
  logic [47:0] bad [5] = '{48'h0004_0001_0001, 48'h0001_0004_0001, 48'h0001_d000_0001,
    48'h0001_0001_0004, 48'h0001_0003_0000};
  int failures = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  dfc_host host (.clk_in(clk), .valid_out(sv), .en_out(se), .temp_out(temp));
  dfc_top #(.CYC_PER_MIN(64'd16), .SAMPLE_PERIOD(sample_period)) DUT (.CLK_IN(clk),
    .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .HARD_RST_IN(hrst), .SETF_WC_VALID_IN(sv), .SETF_WC_EN_IN(se), .CUR_TEMP_IN(temp),
    .SETF_ACK_OUT(), .WC_ACTIVE_OUT(wca), .IDENT_W85_B5_OUT(), .REORDER_EN_OUT());
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ok(input logic [15:0] v);
    return {v, `DFC_STS_OK, `DFC_ERR_OK};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!prdy && n < 20);
    if (!prdy) begin
      failures++;
      print_verdict();
    end else begin
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [15:0] fn, ft, sta, op, input logic [31:0] want);
    apb(1'b1, `DFC_OFF_FUNC, {16'h0, fn});
    apb(1'b1, `DFC_OFF_FEAT, {16'h0, ft});
    apb(1'b1, `DFC_OFF_STATE, {16'h0, sta});
    apb(1'b1, `DFC_OFF_OPT, {16'h0, op});
    apb(1'b1, `DFC_OFF_GO, 32'h1);
    repeat (2) @(posedge clk);
    rd(`DFC_OFF_RESULT, {1'b0, want});
  endtask
  // status word and the cache pin must agree on the true cache state
  task automatic stat(input logic wc);
    rd(`DFC_OFF_STAT, {1'b0, sample_period, 10'h0, wc, 5'h0});
    check({32'h0, wca}, {32'h0, wc});
  endtask
  // results are compared where they appear, oldest note first
  always @(posedge clk) begin
    if (prdy && !pwr) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else check({perr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (140) @(posedge clk);
    stat(1'b1);
    for (int f = 1; f < 4; f++) begin
      cmd(`DFC_FN_GET, f[15:0], 0, 0, ok(16'h1));
    end
    cmd(`DFC_FN_SET, `DFC_FT_WCACHE, `DFC_WC_FORCE_OFF, 0, ok(0));
    host.setf(1'b1);
    stat(1'b0);
    cmd(`DFC_FN_SET, `DFC_FT_WCACHE, `DFC_WC_FORCE_ON, 0, ok(0));
    host.setf(1'b0);
    stat(1'b1);
    cmd(`DFC_FN_SET, `DFC_FT_WCACHE, `DFC_WC_DEFER, 0, ok(0));
    host.setf(1'b0);
    stat(1'b0);
    cmd(`DFC_FN_SET, `DFC_FT_REORDER, `DFC_RO_DISABLE, 0, ok(0));
    cmd(`DFC_FN_GET, `DFC_FT_REORDER, 0, 0, ok(16'h1));
    for (int i = 0; i < 5; i++) begin
      cmd(bad[i][47:32], bad[i][31:16], bad[i][15:0], 0, 32'h5104);
    end
    cmd(`DFC_FN_GET, `DFC_FT_INTERVAL, 0, 0, ok(16'h1));
    r = rnd();
    st = r[15:0] | 16'h8000;
    t = r[23:16];
    host.set_temp(t);
    cmd(`DFC_FN_SET, `DFC_FT_INTERVAL, st, 0, ok(0));
    cmd(`DFC_FN_GET, `DFC_FT_INTERVAL, 0, 0, ok(st));
    repeat (130) @(posedge clk);
    apb(1'b1, `DFC_OFF_HIST, 32'h0);
    rd(`DFC_OFF_HIST, {9'h0, t, 16'h0});
    apb(1'b1, `DFC_OFF_HIST, 32'h7f);
    rd(`DFC_OFF_HIST, 33'h0080007f);
    rd(`DFC_OFF_LIMITS, 33'h0005463c);
    cmd(`DFC_FN_SET, `DFC_FT_WCACHE, `DFC_WC_FORCE_ON, 16'h1, ok(0));
    cmd(`DFC_FN_FLAGS, `DFC_FT_WCACHE, 0, 0, ok(16'h1));
    cmd(`DFC_FN_SET, `DFC_FT_WCACHE, `DFC_WC_FORCE_OFF, 0, ok(0));
    hrst <= 1'b1;
    @(posedge clk);
    hrst <= 1'b0;
    @(posedge clk);
    cmd(`DFC_FN_GET, `DFC_FT_WCACHE, 0, 0, ok(`DFC_WC_FORCE_ON));
    stat(1'b1);
    rd(8'h24, 33'h100000000);
    rd(8'h02, 33'h100000000);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
